// >>> mlc_pkg.sv
package mlc_pkg;
	// count register layout
	localparam int COUNT_WIDTH = 32;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
	// default modulo and thresholds (plain values, software may set others)
	localparam logic [31:0] MODULO_DEFAULT = 32'h0000_03e8;
	localparam logic [31:0] THRESH_A_DEFAULT = 32'h0000_0064;
	localparam logic [31:0] THRESH_B_DEFAULT = 32'h0000_01f4;
	// apb register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CONFIG = 8'h04;
	localparam logic [7:0] OFS_MODULO = 8'h08;
	localparam logic [7:0] OFS_THRESH_A = 8'h0c;
	localparam logic [7:0] OFS_THRESH_B = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_COUNT = 8'h18;
	localparam logic [7:0] OFS_CAPTURE = 8'h1c;
	localparam logic [7:0] OFS_DIAG = 8'h20;
	// control register bit positions
	localparam int CB_EN_ENABLE = 0;
	localparam int CB_EN_SYNC = 1;
	localparam int CB_EN_CAP = 2;
	localparam int CB_EN_COMPARE = 3;
	localparam int CB_ECHO_A = 4;
	localparam int CB_ECHO_B = 5;
	localparam int CB_F_ENABLE = 6;
	localparam int CB_F_SYNC = 7;
	localparam int CB_FORCE_A = 8;
	localparam int CB_FORCE_B = 9;
	localparam int CB_ACK_WRAP = 10;
	localparam int CB_ACK_SYNC = 11;
	localparam int CB_ACK_CAP = 12;
	localparam int CB_HOLD = 13;
	localparam int CTRL_WIDTH = 14;
	localparam logic [13:0] CTRL_RESET = 14'h0000;
	// configuration register bit positions
	localparam int GB_EN_PIN = 0;
	localparam int GB_SYNC_PIN = 1;
	localparam int GB_CAP_PIN = 2;
	localparam int GB_FAST_A = 3;
	localparam int GB_FAST_B = 4;
	localparam int CFG_WIDTH = 5;
	localparam logic [4:0] CFG_RESET = 5'h00;
	// status register bit positions
	localparam int SB_VALID = 0;
	localparam int SB_ERROR = 1;
	localparam int SB_RUN = 2;
	localparam int SB_TH_A = 3;
	localparam int SB_TH_B = 4;
	localparam int SB_WRAP = 5;
	localparam int SB_SYNCED = 6;
	localparam int SB_CAPTURED = 7;
	localparam int SB_FAST_A = 8;
	localparam int SB_FAST_B = 9;
	localparam int SB_PHYS_A = 10;
	localparam int SB_PHYS_B = 11;
	// diagnostic codes
	localparam logic [1:0] DIAG_NONE = 2'h0;
	localparam logic [1:0] DIAG_ORDER = 2'h1;
endpackage

// >>> mlc_counter.sv
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mlc_counter (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic count_a_in,
	input wire logic count_b_in,
	input wire logic enable_pin_in,
	input wire logic sync_pin_in,
	input wire logic capture_pin_in,
	output logic fast_pin_a_out,
	output logic fast_pin_b_out,
	output logic threshold_event_out
);
	// two-flop synchronisers for the field pins
	logic [4:0] pin_s1_r;
	logic [4:0] pin_s2_r;
	logic [4:0] pin_d_r;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_s1_r <= 5'h00;
			pin_s2_r <= 5'h00;
			pin_d_r <= 5'h00;
		end else begin
			pin_s1_r <= {capture_pin_in, sync_pin_in, enable_pin_in, count_b_in, count_a_in};
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
		end
	end

	// rising edges of the synchronised pins
	logic [4:0] pin_rise;
	for (genvar gi = 0; gi < 5; gi++) begin : g_pin_edge
		assign pin_rise[gi] = pin_s2_r[gi] && !pin_d_r[gi];
	end

	// registers software writes, plus the status, count, capture and diag values it only reads
	logic [mlc_pkg::CTRL_WIDTH-1:0] ctrl_r;
	logic [mlc_pkg::CFG_WIDTH-1:0] cfg_r;
	logic [31:0] modulo_r;
	logic [31:0] thresh_a_r;
	logic [31:0] thresh_b_r;
	logic [31:0] status_word;
	logic [31:0] count_r;
	logic [31:0] capture_r;
	logic [1:0] diag_r;
	logic wr_en;
	assign wr_en = psel_in && penable_in && pwrite_in;
	assign pready_out = 1'b1;

	// address decode for pslverr, used on both read and write accesses
	function automatic logic addr_known(input logic [7:0] a);
		case (a)
			mlc_pkg::OFS_CTRL, mlc_pkg::OFS_CONFIG, mlc_pkg::OFS_MODULO,
			mlc_pkg::OFS_THRESH_A, mlc_pkg::OFS_THRESH_B, mlc_pkg::OFS_STATUS,
			mlc_pkg::OFS_COUNT, mlc_pkg::OFS_CAPTURE, mlc_pkg::OFS_DIAG: addr_known = 1'b1;
			default: addr_known = 1'b0;
		endcase
	endfunction
	assign pslverr_out = psel_in && penable_in && !addr_known(paddr_in);

	// register writes
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_r <= mlc_pkg::CTRL_RESET;
			cfg_r <= mlc_pkg::CFG_RESET;
			modulo_r <= mlc_pkg::MODULO_DEFAULT;
			thresh_a_r <= mlc_pkg::THRESH_A_DEFAULT;
			thresh_b_r <= mlc_pkg::THRESH_B_DEFAULT;
		end else if (wr_en) begin
			case (paddr_in)
				mlc_pkg::OFS_CTRL: begin
					ctrl_r <= pwdata_in[mlc_pkg::CTRL_WIDTH-1:0];
				end
				mlc_pkg::OFS_CONFIG: begin
					cfg_r <= pwdata_in[mlc_pkg::CFG_WIDTH-1:0];
				end
				mlc_pkg::OFS_MODULO: begin
					modulo_r <= pwdata_in;
				end
				mlc_pkg::OFS_THRESH_A: begin
					thresh_a_r <= pwdata_in;
				end
				mlc_pkg::OFS_THRESH_B: begin
					thresh_b_r <= pwdata_in;
				end
				default: ;
			endcase
		end
	end

	// read data registered at the edge that ends the setup phase
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			case (paddr_in)
				mlc_pkg::OFS_CTRL: begin
					prdata_out <= {18'h0_0000, ctrl_r};
				end
				mlc_pkg::OFS_CONFIG: begin
					prdata_out <= {27'h000_0000, cfg_r};
				end
				mlc_pkg::OFS_MODULO: begin
					prdata_out <= modulo_r;
				end
				mlc_pkg::OFS_THRESH_A: begin
					prdata_out <= thresh_a_r;
				end
				mlc_pkg::OFS_THRESH_B: begin
					prdata_out <= thresh_b_r;
				end
				mlc_pkg::OFS_STATUS: begin
					prdata_out <= status_word;
				end
				mlc_pkg::OFS_COUNT: begin
					prdata_out <= count_r;
				end
				mlc_pkg::OFS_CAPTURE: begin
					prdata_out <= capture_r;
				end
				mlc_pkg::OFS_DIAG: begin
					prdata_out <= {30'h0000_0000, diag_r};
				end
				default: begin
					prdata_out <= 32'h0000_0000;
				end
			endcase
		end
	end

	// acknowledge edge detection, sampled every clock
	logic [2:0] ack_prev_r;
	logic [2:0] ack_rise;
	logic [2:0] ack_now;
	assign ack_now = {ctrl_r[mlc_pkg::CB_ACK_CAP], ctrl_r[mlc_pkg::CB_ACK_SYNC],
		ctrl_r[mlc_pkg::CB_ACK_WRAP]};
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_prev_r <= 3'h0;
		end else begin
			ack_prev_r <= ack_now;
		end
	end
	assign ack_rise = ack_now & ~ack_prev_r;

	// enable, sync and capture conditions
	logic enable_cond;
	logic sync_cond;
	logic sync_cond_d_r;
	logic sync_event;
	logic cap_event;
	logic captured_r;
	assign enable_cond = ctrl_r[mlc_pkg::CB_F_ENABLE]
		|| (cfg_r[mlc_pkg::GB_EN_PIN] ? (ctrl_r[mlc_pkg::CB_EN_ENABLE] && pin_s2_r[2])
		: 1'b1);
	assign sync_cond = ctrl_r[mlc_pkg::CB_F_SYNC]
		|| (cfg_r[mlc_pkg::GB_SYNC_PIN] && ctrl_r[mlc_pkg::CB_EN_SYNC] && pin_s2_r[3]);
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_cond_d_r <= 1'b0;
		end else begin
			sync_cond_d_r <= sync_cond;
		end
	end
	assign sync_event = sync_cond && !sync_cond_d_r;
	assign cap_event = cfg_r[mlc_pkg::GB_CAP_PIN] && ctrl_r[mlc_pkg::CB_EN_CAP]
		&& pin_rise[4] && !captured_r;

	// counting: rising edge on a counts up, on b counts down
	logic run_r;
	logic step_up;
	logic step_dn;
	logic wrap_event;
	assign step_up = run_r && enable_cond && pin_rise[0];
	assign step_dn = run_r && enable_cond && pin_rise[1] && !step_up;
	assign wrap_event = (step_up && count_r >= modulo_r - 32'h0000_0001)
		|| (step_dn && count_r == 32'h0000_0000);
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_r <= mlc_pkg::COUNT_RESET;
			run_r <= 1'b0;
		end else if (sync_event) begin
			count_r <= mlc_pkg::COUNT_RESET;
			run_r <= 1'b1; // sync starts the counter
		end else if (step_up) begin
			count_r <= wrap_event ? 32'h0000_0000 : count_r + 32'h0000_0001;
		end else if (step_dn) begin
			count_r <= wrap_event ? modulo_r - 32'h0000_0001 : count_r - 32'h0000_0001;
		end
	end

	// capture register, blocked while flag is pending
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			capture_r <= 32'h0000_0000;
		end else if (cap_event) begin
			capture_r <= count_r;
		end
	end

	// sticky flags: set wins over acknowledge
	logic wrap_r;
	logic synced_r;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wrap_r <= 1'b0;
			synced_r <= 1'b0;
			captured_r <= 1'b0;
		end else begin
			wrap_r <= wrap_event || (wrap_r && !ack_rise[0]);
			synced_r <= sync_event || (synced_r && !ack_rise[1]);
			captured_r <= cap_event || (captured_r && !ack_rise[2]);
		end
	end

	// direction of last step, seen in the same cycle as the moved count
	logic step_up_d_r;
	logic step_dn_d_r;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			step_up_d_r <= 1'b0;
			step_dn_d_r <= 1'b0;
		end else begin
			step_up_d_r <= step_up;
			step_dn_d_r <= step_dn;
		end
	end

	// hysteresis step shared by both threshold bits
	function automatic logic hyst_next(
		input logic cur,
		input logic up,
		input logic dn,
		input logic [31:0] value,
		input logic [31:0] limit
	);
		logic result;
		result = cur;
		if (up && $signed(value) >= $signed(limit)) begin
			result = 1'b1;
		end else if (dn && $signed(value) <= $signed(limit)) begin
			result = 1'b0;
		end
		return result;
	endfunction

	// threshold bits with direction hysteresis
	logic th_a_r;
	logic th_b_r;
	logic [31:0] count_next;
	logic cmp_on;
	logic hold;
	assign cmp_on = ctrl_r[mlc_pkg::CB_EN_COMPARE];
	assign hold = ctrl_r[mlc_pkg::CB_HOLD];
	assign count_next = count_r;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			th_a_r <= 1'b0;
			th_b_r <= 1'b0;
		end else if (!cmp_on) begin
			th_a_r <= 1'b0;
			th_b_r <= 1'b0;
		end else begin
			th_a_r <= hyst_next(th_a_r, step_up_d_r, step_dn_d_r,
				count_next, thresh_a_r);
			th_b_r <= hyst_next(th_b_r, step_up_d_r, step_dn_d_r,
				count_next, thresh_b_r);
		end
	end

	// fast outputs: a high between the thresholds, b high from threshold b up
	logic fast_a;
	logic fast_b;
	logic th_a_d_r;
	logic th_b_d_r;
	assign fast_a = cmp_on && th_a_r && !th_b_r;
	assign fast_b = cmp_on && th_b_r;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			th_a_d_r <= 1'b0;
			th_b_d_r <= 1'b0;
			threshold_event_out <= 1'b0;
		end else begin
			th_a_d_r <= th_a_r;
			th_b_d_r <= th_b_r;
			threshold_event_out <= cmp_on && !hold
				&& ((th_a_r != th_a_d_r) || (th_b_r != th_b_d_r));
		end
	end

	// physical lines: force over echo, frozen while held
	logic line_a_nxt;
	logic line_b_nxt;
	// a line follows its fast output only when configured
	function automatic logic line_drive(
		input logic configured,
		input logic force_on,
		input logic echo_on,
		input logic fast_state
	);
		return configured && (force_on || (echo_on && fast_state));
	endfunction
	always_comb begin
		line_a_nxt = line_drive(cfg_r[mlc_pkg::GB_FAST_A], ctrl_r[mlc_pkg::CB_FORCE_A],
			ctrl_r[mlc_pkg::CB_ECHO_A], fast_a);
		line_b_nxt = line_drive(cfg_r[mlc_pkg::GB_FAST_B], ctrl_r[mlc_pkg::CB_FORCE_B],
			ctrl_r[mlc_pkg::CB_ECHO_B], fast_b);
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			fast_pin_a_out <= 1'b0;
			fast_pin_b_out <= 1'b0;
		end else if (!hold) begin
			fast_pin_a_out <= line_a_nxt;
			fast_pin_b_out <= line_b_nxt;
		end
	end

	// order check on threshold and modulo settings, reported as an error
	logic order_bad;
	assign order_bad = !($signed(thresh_a_r) > 0
		&& $signed(thresh_a_r) < $signed(thresh_b_r)
		&& $signed(thresh_b_r) < $signed(modulo_r - 32'h0000_0001));
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			diag_r <= mlc_pkg::DIAG_NONE;
		end else begin
			diag_r <= order_bad ? mlc_pkg::DIAG_ORDER : mlc_pkg::DIAG_NONE;
		end
	end

	// status word: count is signed 32 bit in its own register
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[mlc_pkg::SB_ERROR] = (diag_r != mlc_pkg::DIAG_NONE);
		status_word[mlc_pkg::SB_VALID] = (diag_r == mlc_pkg::DIAG_NONE);
		status_word[mlc_pkg::SB_RUN] = run_r && enable_cond;
		status_word[mlc_pkg::SB_TH_A] = th_a_r;
		status_word[mlc_pkg::SB_TH_B] = th_b_r;
		status_word[mlc_pkg::SB_WRAP] = wrap_r;
		status_word[mlc_pkg::SB_SYNCED] = synced_r;
		status_word[mlc_pkg::SB_CAPTURED] = captured_r;
		status_word[mlc_pkg::SB_FAST_A] = fast_a;
		status_word[mlc_pkg::SB_FAST_B] = fast_b;
		status_word[mlc_pkg::SB_PHYS_A] = cfg_r[mlc_pkg::GB_FAST_A] && fast_pin_a_out;
		status_word[mlc_pkg::SB_PHYS_B] = cfg_r[mlc_pkg::GB_FAST_B] && fast_pin_b_out;
	end
	// count register read as signed value
endmodule
`default_nettype wire

// >>> mlc_counter_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mlc_counter_assertions (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic fast_pin_a_out,
	input wire logic fast_pin_b_out,
	input wire logic threshold_event_out
);
	logic [13:0] ctl_r;
	logic [4:0] cfg_r;
	logic [2:0] calm_r;
	logic acc, wr, calm;
	// accepted writes to control and configuration
	assign acc = psel_in && penable_in;
	assign wr = acc && pwrite_in && (paddr_in == 8'h00 || paddr_in == 8'h04);
	assign calm = calm_r >= 3'h4;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// shadow of the settings software wrote
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctl_r <= 14'h0000;
			cfg_r <= 5'h00;
		end else if (wr && paddr_in == mlc_pkg::OFS_CTRL) begin
			ctl_r <= pwdata_in[13:0];
		end else if (wr) begin
			cfg_r <= pwdata_in[4:0];
		end
	end
	// cycles since the last settings change, saturating
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			calm_r <= 3'h0;
		end else if (wr) begin
			calm_r <= 3'h0;
		end else if (calm_r != 3'h7) begin
			calm_r <= calm_r + 3'h1;
		end
	end
	property p_ready; pready_out; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_err_phase; pslverr_out |-> acc; endproperty
	a_err_phase: assert property (p_err_phase) else $error("error outside access");
	property p_err_unmapped;
		acc && paddr_in > 8'h20 |-> pslverr_out && (pwrite_in || prdata_out == 32'h0000_0000);
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
	property p_line_a;
		calm && !ctl_r[13] && !(cfg_r[3] && (ctl_r[8] || ctl_r[4] && ctl_r[3])) |-> !fast_pin_a_out;
	endproperty
	a_line_a: assert property (p_line_a) else $error("line a high without cause");
	property p_line_b;
		calm && !ctl_r[13] && !(cfg_r[4] && (ctl_r[9] || ctl_r[5] && ctl_r[3])) |-> !fast_pin_b_out;
	endproperty
	a_line_b: assert property (p_line_b) else $error("line b high without cause");
	property p_force_a; calm && cfg_r[3] && ctl_r[8] && !ctl_r[13] |-> fast_pin_a_out; endproperty
	a_force_a: assert property (p_force_a) else $error("force a not applied");
	property p_hold_freeze;
		calm && ctl_r[13] |=> $stable(fast_pin_a_out) && $stable(fast_pin_b_out);
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("line moved in hold");
	property p_hold_mask; calm && ctl_r[13] |-> !threshold_event_out; endproperty
	a_hold_mask: assert property (p_hold_mask) else $error("event in hold");
	c_refused: cover property (acc && pslverr_out);
	c_frozen: cover property (calm && ctl_r[13] && fast_pin_a_out);
	c_event: cover property (threshold_event_out);
endmodule
bind mlc_counter mlc_counter_assertions u_mlc_counter_assertions (.clk_in(clk_in),
	.rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .fast_pin_a_out(fast_pin_a_out),
	.fast_pin_b_out(fast_pin_b_out), .threshold_event_out(threshold_event_out));
`default_nettype wire

// >>> mlc_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module mlc_field_model (
	input wire logic clk_in,
	output logic count_a_out,
	output logic count_b_out,
	output logic sync_out,
	output logic capture_out,
	output logic enable_out
);
	logic [3:0] line_r = 4'h0;
	logic enable_r = 1'b0;
	assign {capture_out, sync_out, count_b_out, count_a_out} = line_r;
	assign enable_out = enable_r;
	// enable level, held until it has passed the synchronisers
	task automatic set_enable(input logic v);
		enable_r <= v;
		repeat (3) @(posedge clk_in);
	endtask
	// clean pulse, wide enough for the pin synchronisers
	task automatic pulse(input logic [3:0] sel);
		line_r <= sel;
		repeat (3) @(posedge clk_in);
		line_r <= 4'h0;
		repeat (4) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [7:0] A_ST = mlc_pkg::OFS_STATUS;
	localparam logic [7:0] A_CN = mlc_pkg::OFS_COUNT;
	localparam logic [7:0] A_CP = mlc_pkg::OFS_CAPTURE;
	logic clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd, ctl;
	logic pready_out, pslverr_out, err, ca, cb, sy, cp, fa, fb, ev, en;
	int n_fail = 0, check_count = 0;
	int n_ev = 0;
	mlc_counter u_mlc_counter (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .count_a_in(ca), .count_b_in(cb), .enable_pin_in(en),
		.sync_pin_in(sy), .capture_pin_in(cp), .fast_pin_a_out(fa), .fast_pin_b_out(fb),
		.threshold_event_out(ev));
	mlc_field_model u_mlc_field_model (.clk_in(clk_in), .count_a_out(ca),
		.count_b_out(cb), .sync_out(sy), .capture_out(cp), .enable_out(en));
	initial forever #12.5 clk_in = ~clk_in;
	// threshold event pulses, counted away from the launching edge
	always @(negedge clk_in) begin
		if (ev === 1'b1) begin
			n_ev++;
		end
	end
	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		@(posedge clk_in);
		while (pready_out !== 1'b1) @(posedge clk_in);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected reg %h expected %h seen %h", a, e, g);
		end
	endtask
	task automatic rs(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(a, e, rd & m);
	endtask
	task automatic wc(input logic [31:0] v);
		ctl = v;
		apb(1'b1, mlc_pkg::OFS_CTRL, v);
	endtask
	task automatic pu(input logic [3:0] s, input int n);
		repeat (n) u_mlc_field_model.pulse(s);
	endtask
	task automatic complete_run;
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#(25 * 5000);
		n_fail++;
		complete_run();
	end
	initial begin
		ctl = 32'h0000_0000;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		// reset values, unmapped read refused
		rs(mlc_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_0000);
		rs(mlc_pkg::OFS_MODULO, 32'hffff_ffff, mlc_pkg::MODULO_DEFAULT);
		rs(A_ST, 32'h0000_0fff, 32'h0000_0001);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk(8'h40, 32'h0000_0001, {rd[30:0], err});
		// small loop: modulo 10, thresholds 3 and 6
		apb(1'b1, mlc_pkg::OFS_MODULO, 32'h0000_000a);
		apb(1'b1, mlc_pkg::OFS_THRESH_A, 32'h0000_0003);
		apb(1'b1, mlc_pkg::OFS_THRESH_B, 32'h0000_0006);
		apb(1'b1, mlc_pkg::OFS_CONFIG, 32'h0000_001e);
		// sync pin ignored without permit, then starts the count
		pu(4'h4, 1);
		rs(A_ST, 32'h0000_0044, 32'h0000_0000);
		wc(32'h0000_003a);
		pu(4'h4, 1);
		rs(A_ST, 32'h0000_0045, 32'h0000_0045);
		rs(A_CN, 32'hffff_ffff, 32'h0000_0000);
		// thresholds, fast states and echo
		pu(4'h1, 4);
		rs(A_ST, 32'h0000_0f18, 32'h0000_0508);
		chk(8'hf0, 32'h0000_0001, {31'h0, fa});
		pu(4'h1, 3);
		rs(A_ST, 32'h0000_0f18, 32'h0000_0a18);
		chk(8'hf1, 32'h0000_0001, {31'h0, fb});
		pu(4'h2, 1);
		rs(A_CN, 32'hffff_ffff, 32'h0000_0006);
		rs(A_ST, 32'h0000_0010, 32'h0000_0000);
		// wrap up past modulo, acknowledge, wrap down past zero
		pu(4'h1, 4);
		rs(A_CN, 32'hffff_ffff, 32'h0000_0000);
		rs(A_ST, 32'h0000_0020, 32'h0000_0020);
		wc(ctl | 32'h0000_0400);
		rs(A_ST, 32'h0000_0020, 32'h0000_0000);
		pu(4'h2, 1);
		rs(A_CN, 32'hffff_ffff, 32'h0000_0009);
		rs(A_ST, 32'h0000_0020, 32'h0000_0020);
		chk(8'he0, 32'h0000_0004, n_ev);
		// capture needs its permit, then blocks until acknowledged
		pu(4'h8, 1);
		rs(A_ST, 32'h0000_0080, 32'h0000_0000);
		wc(ctl | 32'h0000_0004);
		pu(4'h8, 1);
		rs(A_CP, 32'hffff_ffff, 32'h0000_0009);
		rs(A_ST, 32'h0000_0080, 32'h0000_0080);
		pu(4'h1, 1);
		pu(4'h8, 1);
		rs(A_CP, 32'hffff_ffff, 32'h0000_0009);
		wc(ctl | 32'h0000_1000);
		rs(A_ST, 32'h0000_0080, 32'h0000_0000);
		pu(4'h8, 1);
		rs(A_CP, 32'hffff_ffff, 32'h0000_0000);
		// force line a, then hold keeps it after the force is dropped
		wc(ctl | 32'h0000_0100);
		rs(A_ST, 32'h0000_0400, 32'h0000_0400);
		chk(8'hf0, 32'h0000_0001, {31'h0, fa});
		wc(ctl | 32'h0000_2000);
		wc(ctl & 32'hffff_feff);
		rs(A_ST, 32'h0000_0400, 32'h0000_0400);
		chk(8'hf0, 32'h0000_0001, {31'h0, fa});
		// enable pin needs its permit, enable force overrides both
		apb(1'b1, mlc_pkg::OFS_CONFIG, 32'h0000_001f);
		u_mlc_field_model.set_enable(1'b1);
		pu(4'h1, 1);
		rs(A_CN, 32'hffff_ffff, 32'h0000_0000);
		wc(ctl | 32'h0000_0001);
		pu(4'h1, 1);
		rs(A_CN, 32'hffff_ffff, 32'h0000_0001);
		rs(A_ST, 32'h0000_0004, 32'h0000_0004);
		u_mlc_field_model.set_enable(1'b0);
		pu(4'h1, 1);
		rs(A_CN, 32'hffff_ffff, 32'h0000_0001);
		rs(A_ST, 32'h0000_0004, 32'h0000_0000);
		wc(ctl | 32'h0000_0040);
		pu(4'h1, 4);
		rs(A_CN, 32'hffff_ffff, 32'h0000_0005);
		// compare keeps working in hold, its event stays masked
		pu(4'h2, 1);
		rs(A_ST, 32'h0000_0018, 32'h0000_0008);
		chk(8'he0, 32'h0000_0004, n_ev);
		// sync force restarts the count without the pin
		wc(ctl | 32'h0000_0080);
		rs(A_CN, 32'hffff_ffff, 32'h0000_0000);
		// broken threshold order flags an error
		apb(1'b1, mlc_pkg::OFS_THRESH_A, 32'h0000_0007);
		rs(A_ST, 32'h0000_0003, 32'h0000_0002);
		rs(mlc_pkg::OFS_DIAG, 32'h0000_0003, {30'h0, mlc_pkg::DIAG_ORDER});
		complete_run();
	end
endmodule
`default_nettype wire
